// ===== dv/lds_host_model.sv
// Host controller model driving the three-wire link.
module lds_host_model (
    input wire logic REF_CLK,      // Pacing clock
    output logic     SHIFT_CLK,    // Shift clock pin
    output logic     SERIAL_IN,    // Serial data pin
    output logic     LATCH_STROBE  // Latch strobe pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link: clock still, strobe high
    initial
    begin
        SHIFT_CLK    = 1'b0;
        SERIAL_IN    = 1'b0;
        LATCH_STROBE = 1'b1;
    end

    // Waits whole reference cycles
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask

    // Opens a frame and keeps the strobe low
    task automatic open_frame();
        @(posedge REF_CLK);
        LATCH_STROBE <= 1'b0;
        wait_cyc(8);
    endtask

    // One bit in two halves; half of 10 or more keeps the clock in range
    task automatic send_bit(input logic b, input int half);
        @(posedge REF_CLK);
        SHIFT_CLK <= 1'b0;
        SERIAL_IN <= b;
        wait_cyc(half);
        SHIFT_CLK <= 1'b1;
        wait_cyc(half - 1); // Next call's edge completes the high half
    endtask

    // Closes a frame; data line no longer shows the last bit
    task automatic close_frame(input int half);
        @(posedge REF_CLK);
        SHIFT_CLK <= 1'b0;
        wait_cyc(half);
        LATCH_STROBE <= 1'b1;
        SERIAL_IN    <= ~SERIAL_IN;
        wait_cyc(8);
    endtask

    // Shift clock pulses with the strobe high
    task automatic idle_clk(input int n);
        repeat (n)
        begin
            @(posedge REF_CLK);
            SHIFT_CLK <= 1'b1;
            wait_cyc(16);
            SHIFT_CLK <= 1'b0;
            wait_cyc(16);
        end
    endtask
endmodule

// ===== dv/lds_top_chk.sv
// Port-level assertions for the serial shift port.
module lds_top_chk (
    input wire logic              REF_CLK,       // Reference clock
    input wire logic              ARST_N,        // Reset, active low
    input wire logic              SHIFT_CLK,     // Shift clock pin
    input wire logic              LATCH_STROBE,  // Latch strobe pin
    input wire logic              SERIAL_OUT,    // Chained data
    input wire logic              SERIAL_OUT_OE, // Drive enable
    input wire logic              CMD_VALID,     // Word available
    input wire logic              CMD_READY,     // Core takes word
    input wire lds_pkg::lds_cmd_s CMD_WORD,      // Oldest word
    input wire logic              DISPLAY_BLANK  // Display blanked
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       sclk_q;  // Shift clock one cycle back
    logic       strb_q;  // Strobe one cycle back
    logic [7:0] rise_q;  // Cycles since shift clock rise
    logic [7:0] rise_d;  // Next value
    logic [7:0] lat_q;   // Cycles since strobe rise
    logic [7:0] lat_d;   // Next value
    logic [7:0] hi_q;    // Cycles strobe held high
    logic [7:0] hi_d;    // Next value

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    // Saturating age counters of pin events
    always_comb
    begin
        rise_d = (SHIFT_CLK && !sclk_q) ? 8'h00 : rise_q + 8'(rise_q != 8'hff);
        lat_d  = (LATCH_STROBE && !strb_q) ? 8'h00 : lat_q + 8'(lat_q != 8'hff);
        hi_d   = !LATCH_STROBE ? 8'h00 : hi_q + 8'(hi_q != 8'hff);
    end

    // Registers of the counters
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sclk_q <= 1'b0;
            strb_q <= 1'b1;
            rise_q <= 8'hff;
            lat_q  <= 8'hff;
            hi_q   <= 8'h00;
        end
        else
        begin
            sclk_q <= SHIFT_CLK;
            strb_q <= LATCH_STROBE;
            rise_q <= rise_d;
            lat_q  <= lat_d;
            hi_q   <= hi_d;
        end
    end

    a_oe_always_on: assert property (SERIAL_OUT_OE)
        else $error("serial output released");
    a_out_on_rise: assert property ($changed(SERIAL_OUT) |-> rise_q inside {[2:9]})
        else $error("serial output moved without a shift clock rise");
    a_frozen_strobe_high: assert property (hi_q >= 8'd12 |-> $stable(SERIAL_OUT))
        else $error("serial output moved while strobe high");
    a_push_after_latch: assert property ($rose(CMD_VALID) |-> lat_q inside {[2:10]})
        else $error("word appeared without a strobe rise");
    a_word_holds: assert property (CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD_WORD))
        else $error("word changed before it was taken");
    a_pop_only: assert property ($fell(CMD_VALID) |-> $past(CMD_READY))
        else $error("word vanished without being taken");
    a_blank_hold: assert property (DISPLAY_BLANK && !(CMD_VALID && CMD_READY) |=> DISPLAY_BLANK)
        else $error("display unblanked before programming");
    a_blank_clear: assert property (CMD_VALID && CMD_READY |=> !DISPLAY_BLANK)
        else $error("display still blank after a word");
endmodule

bind lds_top lds_top_chk u_chk (
    .REF_CLK      (REF_CLK),
    .ARST_N       (ARST_N),
    .SHIFT_CLK    (SHIFT_CLK),
    .LATCH_STROBE (LATCH_STROBE),
    .SERIAL_OUT   (SERIAL_OUT),
    .SERIAL_OUT_OE(SERIAL_OUT_OE),
    .CMD_VALID    (CMD_VALID),
    .CMD_READY    (CMD_READY),
    .CMD_WORD     (CMD_WORD),
    .DISPLAY_BLANK(DISPLAY_BLANK)
);

// ===== dv/tb_top.sv
// Self-checking bench for the serial shift port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk    = 1'b0;     // 200 MHz reference
    logic               arst_n     = 1'b0;     // Reset, active low
    logic               cmd_ready  = 1'b0;     // Core takes words
    logic               status_clr = 1'b0;     // Clears flags
    logic               rdy_en     = 1'b0;     // Random drain on
    wire logic          sclk;                  // Shift clock pin
    wire logic          sdin;                  // Serial data pin
    wire logic          strobe;                // Latch strobe pin
    logic               serial_out;            // Chained data
    logic               oe;                    // Drive enable
    logic               cmd_valid;             // Word available
    logic               blank;                 // Display blanked
    lds_pkg::lds_cmd_s  cmd_word;              // Oldest word
    lds_pkg::lds_stat_s status;                // Sticky flags
    logic [15:0]        ref_sr     = 16'h0000; // Expected shift register
    logic               last_out   = 1'b0;     // Expected output level
    logic [15:0]        exp_q[$];              // Expected words
    int                 errors     = 0;        // Mismatches
    int                 checks     = 0;        // Comparisons
    int                 cycles     = 0;        // Run length
    int                 seed       = 90433;    // Random seed

    always #2.5 ref_clk = ~ref_clk;

    lds_host_model u_host (.REF_CLK(ref_clk), .SHIFT_CLK(sclk), .SERIAL_IN(sdin), .LATCH_STROBE(strobe));

    lds_top u_dut (
        .REF_CLK      (ref_clk),
        .ARST_N       (arst_n),
        .SHIFT_CLK    (sclk),
        .SERIAL_IN    (sdin),
        .LATCH_STROBE (strobe),
        .SERIAL_OUT   (serial_out),
        .SERIAL_OUT_OE(oe),
        .CMD_VALID    (cmd_valid),
        .CMD_READY    (cmd_ready),
        .CMD_WORD     (cmd_word),
        .DISPLAY_BLANK(blank),
        .STATUS       (status),
        .STATUS_CLR   (status_clr)
    );

    // Prints the counts and the verdict
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Compares one value and counts it
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            $display("MISMATCH timeout expected 0 seen %0d", cycles);
            end_sim();
        end
    end

    // Core side stalls at random while draining
    always @(posedge ref_clk)
        cmd_ready <= rdy_en & 1'($random(seed));

    // Each word taken must be the oldest expected
    always @(posedge ref_clk)
        if (arst_n && cmd_valid === 1'b1 && cmd_ready === 1'b1)
            chk("cmd_word", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, cmd_word);

    // Shifts n bits MSB first and checks the echo per bit
    task automatic send(input logic [19:0] v, input int n, input int half);
        logic b;
        u_host.open_frame();
        for (int i = n - 1; i >= 0; i--)
        begin
            b = v[i];
            last_out = ref_sr[15];
            u_host.send_bit(b, half);
            #1;
            chk("serial_out", 16'(last_out), 16'(serial_out));
            ref_sr = {ref_sr[14:0], b};
        end
        if (exp_q.size() < 16)
            exp_q.push_back(ref_sr);
        u_host.close_frame(half);
    endtask

    // Drains the buffer under a bound
    task automatic drain();
        rdy_en = 1'b1;
        for (int i = 0; i < 400 && (exp_q.size() > 0 || cmd_valid !== 1'b0); i++)
            @(posedge ref_clk);
        rdy_en = 1'b0;
        chk("drained", 16'h0000, 16'(exp_q.size()));
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        chk("oe", 16'h0001, 16'(oe));
        chk("blank", 16'h0001, 16'(blank));
        chk("valid", 16'h0000, 16'(cmd_valid));
        arst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        send(20'h00000, 16, 16);
        chk("blank", 16'h0001, 16'(blank));
        rdy_en = 1'b1;
        send(20'h0ffff, 16, 16);
        send(20'h08001, 16, 16);
        repeat (5) send(20'($random(seed)), 16, 16);
        send(20'($random(seed)), 20, 16);
        drain();
        chk("blank", 16'h0000, 16'(blank));
        chk("no_flags", 16'h0000, 16'(status));
        u_host.idle_clk(4);
        chk("frozen", 16'(last_out), 16'(serial_out));
        chk("no_word", 16'h0000, 16'(cmd_valid));
        repeat (17) send(20'($random(seed)), 16, 16);
        chk("overflow", 16'h0001, 16'(status.overflow));
        drain();
        send(20'($random(seed)), 8, 16);
        chk("short", 16'h0001, 16'(status.short_frame));
        send(20'($random(seed)), 16, 8);
        chk("rate", 16'h0001, 16'(status.rate_err));
        drain();
        @(posedge ref_clk);
        status_clr <= 1'b1;
        @(posedge ref_clk);
        status_clr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("status", 16'h0000, 16'(status));
        chk("oe", 16'h0001, 16'(oe));
        end_sim();
    end
endmodule

// ===== logic/lds_defines.svh
// Constants of the serial shift port of the LED driver.
// Overview of operation
// RULE_01: Shift clock rise shifts serial input in.
// RULE_02: Shifting accepted only while latch strobe low.
// RULE_03: Strobe rise captures last 16 bits.
// RULE_04: Serial output echoes input 16 clocks later.
// RULE_05: Serial output changes on shift clock rise.
// RULE_06: Serial output always driven, never released.
// RULE_07: Host keeps shift clock at most 10MHz.
// RULE_08: Display blanked after power-up until programmed.
// RULE_09: Strobe high freezes shift register and output.
`ifndef LDS_DEFINES_SVH
`define LDS_DEFINES_SVH

// Word and buffer geometry
`define LDS_WORD_W          16
`define LDS_FIFO_DEPTH      16
`define LDS_ADDR_LSB        8
`define LDS_DATA_LSB        0

// Reset values
`define LDS_SR_RST          16'h0000
`define LDS_SOUT_RST        1'b0
`define LDS_STROBE_RST      1'b1
`define LDS_BLANK_RST       1'b1

// Timing: reference clock rate and least shift clock period
`define LDS_REF_CLK_MHZ     200
`define LDS_SCL_MIN_PER_NS  100
`define LDS_SCL_MIN_CYC     ((`LDS_SCL_MIN_PER_NS * `LDS_REF_CLK_MHZ + 999) / 1000)
`define LDS_SYNC_JITTER     2
`define LDS_GAP_MIN         8'(`LDS_SCL_MIN_CYC - `LDS_SYNC_JITTER)
`define LDS_GAP_MAX         8'hff

`endif

// ===== logic/lds_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
module lds_fifo #(
    parameter int WIDTH = 16,             // Word width
    parameter int DEPTH = 16              // Number of words
) (
    input  wire logic             clk,       // Reference clock
    input  wire logic             arst_n,    // Asynchronous reset, active low
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word written
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Drain takes the word
    output logic      [WIDTH-1:0] out_data   // Oldest word
);

    localparam int AW = $clog2(DEPTH);    // Index width
    localparam int CW = $clog2(DEPTH + 1); // Fill count width

    logic [WIDTH-1:0] mem_q [DEPTH];      // Storage
    logic [WIDTH-1:0] mem_d [DEPTH];      // Next storage
    logic [AW-1:0]    wr_q;               // Write index
    logic [AW-1:0]    wr_d;               // Next write index
    logic [AW-1:0]    rd_q;               // Read index
    logic [AW-1:0]    rd_d;               // Next read index
    logic [CW-1:0]    cnt_q;              // Fill count
    logic [CW-1:0]    cnt_d;              // Next fill count
    logic             push;               // Write this cycle
    logic             pop;                // Read this cycle

    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // Next storage, indices and count
    always_comb
    begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_data;
            wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        unique case ({push, pop})
            2'b10:   cnt_d = cnt_q + 1'b1; // Fill only
            2'b01:   cnt_d = cnt_q - 1'b1; // Drain only
            default: cnt_d = cnt_q;        // Both or neither
        endcase
    end

    // Registers of the FIFO
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

// ===== logic/lds_pkg.sv
// Types shared by the serial shift port modules.
`include "lds_defines.svh"
package lds_pkg;

    // Latched command word as passed to the driver core
    typedef struct packed {
        logic [7:0] addr;                 // Upper byte, register address
        logic [7:0] data;                 // Lower byte, register data
    } lds_cmd_s;

    // Sticky link status flags
    typedef struct packed {
        logic overflow;                   // Word latched while buffer full
        logic rate_err;                   // Shift clock edges closer than allowed
        logic short_frame;                // Fewer than 16 bits shifted in a frame
    } lds_stat_s;

    // Link phase, Gray coded along idle, shift, latch
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,                 // Strobe high, link frozen
        ST_SHIFT = 2'b01,                 // Strobe low, bits accepted
        ST_LATCH = 2'b11                  // Strobe just rose, word captured
    } lds_state_e;

    typedef logic [4:0] lds_cnt_t;        // Bit counter, saturates at 16
    typedef logic [7:0] lds_gap_t;        // Reference cycles between clock edges

endpackage

// ===== logic/lds_sync.sv
// Three-stage input synchroniser with agreement filter.
module lds_sync #(
    parameter logic RST_VAL = 1'b0        // Level held during reset
) (
    input  wire logic clk,                // Reference clock
    input  wire logic arst_n,             // Asynchronous reset, active low
    input  wire logic pin,                // Asynchronous input
    output logic      level               // Filtered synchronous level
);

    logic ff1_q;                          // First stage, read by second only
    logic ff2_q;                          // Second stage
    logic ff3_q;                          // Third stage
    logic lvl_q;                          // Accepted level
    logic lvl_d;                          // Next accepted level

    // A change counts once the second and third stage agree
    always_comb
    begin
        lvl_d = lvl_q;
        if (ff2_q == ff3_q)
        begin
            lvl_d = ff3_q;                // Stages agree, take it
        end
    end

    // Registers of the chain
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ff1_q <= RST_VAL;
            ff2_q <= RST_VAL;
            ff3_q <= RST_VAL;
            lvl_q <= RST_VAL;
        end
        else
        begin
            ff1_q <= pin;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;

endmodule

// ===== logic/lds_top.sv
// Serial shift port of the LED driver: shifter, echo, latch and command buffer.
`include "lds_defines.svh"
module lds_top (
    input  wire logic              REF_CLK,       // Reference clock, 200 MHz
    input  wire logic              ARST_N,        // Asynchronous reset, active low
    input  wire logic              SHIFT_CLK,     // Serial shift clock pin
    input  wire logic              SERIAL_IN,     // Serial data pin
    input  wire logic              LATCH_STROBE,  // Latch strobe pin
    output logic                   SERIAL_OUT,    // Chained serial data
    output logic                   SERIAL_OUT_OE, // Serial data drive enable
    output logic                   CMD_VALID,     // Command word available
    input  wire logic              CMD_READY,     // Core takes the word
    output lds_pkg::lds_cmd_s      CMD_WORD,      // Oldest command word
    output logic                   DISPLAY_BLANK, // Display held blank
    output lds_pkg::lds_stat_s     STATUS,        // Sticky link status
    input  wire logic              STATUS_CLR     // Clears all status flags
);

    // Synchronised pin levels
    logic                   scl_s;        // Shift clock level
    logic                   sin_s;        // Serial data level
    logic                   ld_s;         // Latch strobe level

    // Edge detection
    logic                   scl_prev_q;   // Shift clock one cycle ago
    logic                   ld_prev_q;    // Strobe one cycle ago
    logic                   scl_rise;     // Shift clock rising this cycle
    logic                   ld_rise;      // Strobe rising this cycle
    logic                   ld_fall;      // Strobe falling this cycle

    // Link phase
    lds_pkg::lds_state_e    state_q;      // Current phase
    lds_pkg::lds_state_e    state_d;      // Next phase

    // Shift path
    logic [`LDS_WORD_W-1:0] sr_q;         // Shift register
    logic [`LDS_WORD_W-1:0] sr_d;         // Next shift register
    logic                   sout_q;       // Serial output register
    logic                   sout_d;       // Next serial output
    lds_pkg::lds_cnt_t      bits_q;       // Bits shifted this frame
    lds_pkg::lds_cnt_t      bits_d;       // Next bit count

    // Shift clock rate watch
    lds_pkg::lds_gap_t      gap_q;        // Cycles since last rise
    lds_pkg::lds_gap_t      gap_d;        // Next gap count
    logic                   seen_q;       // A rise seen in this frame
    logic                   seen_d;       // Next seen flag

    // Status and display
    lds_pkg::lds_stat_s     stat_q;       // Sticky flags
    lds_pkg::lds_stat_s     stat_d;       // Next sticky flags
    lds_pkg::lds_stat_s     stat_set;     // Events this cycle
    logic                   blank_q;      // Display blank
    logic                   blank_d;      // Next display blank

    // Buffer ports
    logic                   push_valid;   // Word offered to buffer
    logic                   push_ready;   // Buffer has room
    lds_pkg::lds_cmd_s      push_word;    // Word offered
    logic                   pop_valid;    // Buffer holds a word
    lds_pkg::lds_cmd_s      pop_word;     // Oldest word
    logic                   pop_fire;     // Core takes a word now

    // Pin synchronisers
    lds_sync #(
        .RST_VAL (1'b0)
    ) u_sync_scl (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .pin    (SHIFT_CLK),
        .level  (scl_s)
    );

    lds_sync #(
        .RST_VAL (1'b0)
    ) u_sync_sin (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .pin    (SERIAL_IN),
        .level  (sin_s)
    );

    lds_sync #(
        .RST_VAL (`LDS_STROBE_RST)
    ) u_sync_ld (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .pin    (LATCH_STROBE),
        .level  (ld_s)
    );

    // Edges of the filtered levels
    assign scl_rise = scl_s && !scl_prev_q;
    assign ld_rise  = ld_s && !ld_prev_q;
    assign ld_fall  = !ld_s && ld_prev_q;

    // Edge history registers
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            scl_prev_q <= 1'b0;
            ld_prev_q  <= `LDS_STROBE_RST;
        end
        else
        begin
            scl_prev_q <= scl_s;
            ld_prev_q  <= ld_s;
        end
    end

    // Link phase sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            lds_pkg::ST_IDLE:
            begin
                if (ld_fall)
                begin
                    state_d = lds_pkg::ST_SHIFT;   // Frame opens
                end
            end
            lds_pkg::ST_SHIFT:
            begin
                if (ld_rise)
                begin
                    state_d = lds_pkg::ST_LATCH;   // Frame closes [RULE_03]
                end
            end
            lds_pkg::ST_LATCH:
            begin
                state_d = lds_pkg::ST_IDLE;        // One cycle to hand over
            end
            default:
            begin
                state_d = lds_pkg::ST_IDLE;        // Illegal code recovers
            end
        endcase
    end

    // Link phase register
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q <= lds_pkg::ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Shift register, echo output and bit count
    always_comb
    begin
        sr_d   = sr_q;
        sout_d = sout_q;
        bits_d = bits_q;
        if (state_q == lds_pkg::ST_IDLE && ld_fall)
        begin
            bits_d = '0;                           // New frame, count anew
        end
        else if (state_q == lds_pkg::ST_SHIFT && !ld_s && scl_rise) // [RULE_02] [RULE_09]
        begin
            sr_d   = {sr_q[`LDS_WORD_W-2:0], sin_s}; // [RULE_01]
            sout_d = sr_q[`LDS_WORD_W-1];          // Bit from 16 edges back [RULE_04] [RULE_05]
            if (bits_q != 5'(`LDS_WORD_W))
            begin
                bits_d = bits_q + 1'b1;            // Saturate at a full word
            end
        end
    end

    // Shift path registers
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sr_q   <= `LDS_SR_RST;
            sout_q <= `LDS_SOUT_RST;
            bits_q <= '0;
        end
        else
        begin
            sr_q   <= sr_d;
            sout_q <= sout_d;
            bits_q <= bits_d;
        end
    end

    // Pin drive, enable held high at all times
    assign SERIAL_OUT    = sout_q;
    assign SERIAL_OUT_OE = 1'b1;                   // [RULE_06]

    // Gap between shift clock rises, checked against the least period
    always_comb
    begin
        gap_d  = gap_q;
        seen_d = seen_q;
        if (state_q != lds_pkg::ST_SHIFT)
        begin
            seen_d = 1'b0;                         // Rate judged inside a frame only
            gap_d  = '0;
        end
        else if (scl_rise)
        begin
            seen_d = 1'b1;
            gap_d  = '0;
        end
        else if (gap_q != `LDS_GAP_MAX)
        begin
            gap_d = gap_q + 1'b1;                  // Saturating count
        end
    end

    // Rate watch registers
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            gap_q  <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= gap_d;
            seen_q <= seen_d;
        end
    end

    // Word handed to the buffer in the cycle after the strobe rises
    assign push_valid = (state_q == lds_pkg::ST_LATCH);
    assign push_word  = lds_pkg::lds_cmd_s'(sr_q); // Last 16 bits shifted [RULE_03]

    // Events that raise status flags
    always_comb
    begin
        stat_set             = '0;
        stat_set.overflow    = push_valid && !push_ready;            // Word lost, buffer full
        stat_set.rate_err    = (state_q == lds_pkg::ST_SHIFT) && scl_rise
                               && seen_q && (gap_q < `LDS_GAP_MIN);  // [RULE_07]
        stat_set.short_frame = push_valid && (bits_q != 5'(`LDS_WORD_W));
    end

    // Status flags and display blank
    always_comb
    begin
        stat_d  = STATUS_CLR ? '0 : stat_q;
        stat_d  = stat_d | stat_set;               // Set wins over clear
        blank_d = blank_q;
        if (pop_fire)
        begin
            blank_d = 1'b0;                        // Core programmed [RULE_08]
        end
    end

    // Status and display registers
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            stat_q  <= '0;
            blank_q <= `LDS_BLANK_RST;             // Blank from power-up [RULE_08]
        end
        else
        begin
            stat_q  <= stat_d;
            blank_q <= blank_d;
        end
    end

    // Command buffer between latch and driver core
    lds_fifo #(
        .WIDTH (`LDS_WORD_W),
        .DEPTH (`LDS_FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .arst_n    (ARST_N),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (pop_valid),
        .out_ready (CMD_READY),
        .out_data  (pop_word)
    );

    // Core side of the buffer
    assign pop_fire      = pop_valid && CMD_READY;
    assign CMD_VALID     = pop_valid;
    assign CMD_WORD      = pop_word;
    assign DISPLAY_BLANK = blank_q;
    assign STATUS        = stat_q;

endmodule
